// File: dv/reset_source_combiner_and_flags_tb.sv
`timescale 1ns/1ns
module reset_source_combiner_and_flags_tb;
	// Bus and design signals.
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0, fuse = 2'h0;
	logic        hready, hreadyout, hresp, sys_rst, bo_en, ret_sel, pm_keep, wd_en;
	// Source requests and the model's lines.
	logic        go = 1'b0, seen;
	logic [3:0]  idx = 4'h0;
	logic [11:0] src;
	logic [31:0] seed = 32'd44, v;
	int          mismatches = 0, checks = 0;

	// Clock of 50 ns; the single slave's ready is the bus ready.
	always #25 hclk = ~hclk;
	assign hready = hreadyout;

	reset_sources_model partner (.hclk(hclk), .go(go), .idx(idx), .src(src));

	reset_source_combiner_and_flags uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .power_on_detect(src[9]),
		.brownout_detect(src[6]), .low_power_brownout(src[7]),
		.master_clear_pin_n(~src[8]), .reset_instruction(src[0]), .watchdog_reset(src[1]),
		.trap_conflict(src[2]), .illegal_opcode(src[3]), .uninit_wreg_reset(src[4]),
		.config_mismatch(src[5]), .sleep_entry(src[10]), .idle_entry(src[11]),
		.fuse_watchdog_mode(fuse), .system_reset_out(sys_rst),
		.brownout_detector_enable(bo_en), .retention_regulator_select(ret_sel),
		.progmem_bias_keep(pm_keep), .watchdog_enable(wd_en));

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run.
	task automatic end_of_test();
		if (mismatches == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	// Compares one value and reports a mismatch.
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// Waits for ready at a rising edge, with a bound.
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100) begin
			mismatches++;
			end_of_test();
		end
	endtask : wait_rdy

	// One single-word transfer: address phase, then data phase.
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask : ahb

	// Repeatable random numbers.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Register expected after the base write (zero for source 1) and source i.
	function automatic logic [15:0] exp_flags(input int i);
		case (i)
			0: return 16'h0050;
			1: return 16'h0010;
			2: return 16'h8010;
			3, 4: return 16'h4010;
			5: return 16'h0210;
			6, 7: return 16'h0012;
			8: return 16'h0090;
			9: return 16'h0003;
			10: return 16'h0008;
			default: return 16'h0004;
		endcase
	endfunction : exp_flags

	// Starts source i and watches the combined reset for twelve cycles.
	task automatic fire(input int i);
		seen = 1'b0;
		go <= 1'b1;
		idx <= 4'(i);
		@(posedge hclk);
		go <= 1'b0;
		repeat (12) begin
			@(posedge hclk);
			if (sys_rst === 1'b1) seen = 1'b1;
		end
	endtask : fire

	////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, register access, then every source in turn.
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 32'h0, 32'h0);
		cmp(rd, 32'h0000_0003);
		ahb(1'b1, 32'h10, 32'hffff_ffff);
		ahb(1'b0, 32'h10, 32'h0);
		cmp(rd, 32'h0);
		for (int k = 0; k < 8; k++) begin
			v = xs();
			fuse <= 2'(k);
			ahb(1'b1, 32'h0, v);
			ahb(1'b0, 32'h0, 32'h0);
			cmp(rd, {16'h0, v[15:0] & 16'hf3ff});
			cmp({28'h0, bo_en, ret_sel, pm_keep, wd_en},
			    {28'h0, v[13], v[12], v[8], v[5] | (fuse == 2'h3)});
			cmp({30'h0, hresp, sys_rst}, 32'h0);
		end
		for (int i = 0; i < 12; i++) begin
			ahb(1'b1, 32'h0, (i == 1) ? 32'h0 : 32'h10);
			fire(i);
			cmp({31'h0, seen}, {31'h0, i < 10});
			ahb(1'b0, 32'h0, 32'h0);
			cmp(rd, {16'h0, exp_flags(i)});
		end
		// A trap pulse lands in the data phase of a write of zero.
		go <= 1'b1;
		idx <= 4'h2;
		fork
			ahb(1'b1, 32'h0, 32'h0);
			begin
				@(posedge hclk);
				go <= 1'b0;
			end
		join
		ahb(1'b0, 32'h0, 32'h0);
		cmp(rd, 32'h0000_8000);
		end_of_test();
	end
endmodule : reset_source_combiner_and_flags_tb

// File: dv/reset_sources_model.sv
`timescale 1ns/1ns
module reset_sources_model (
	// Clock of the core side.
	input  wire logic        hclk,
	// Request from the bench: start source idx.
	input  wire logic        go,
	input  wire logic [3:0]  idx,
	// One line per source, active high.
	output logic      [11:0] src
);
	// Selected source and its remaining active cycles.
	logic [3:0] sel_reg = 4'h0;
	logic [2:0] cnt_reg = 3'h0;

	////////////////////////////////////////////////////////////////////////
	// Core sources pulse for one cycle; detectors and the pin stay long enough to pass the
	// two-flop synchroniser, which a single cycle might not.
	always_ff @(posedge hclk) begin
		if (go) begin
			sel_reg <= idx;
			cnt_reg <= (idx >= 4'h6 && idx <= 4'h9) ? 3'h4 : 3'h1;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end
	end

	// Only the selected line is driven while the count runs.
	assign src = (cnt_reg != 3'h0) ? (12'h001 << sel_reg) : 12'h000;
endmodule : reset_sources_model

// File: verilog/reset_combiner_pkg.sv
// Overview of operation
// (R1) Merge all reset requests into one output.
// (R2) Any active source drives system reset active.
// (R3) Each reset sets its own status flag.
// (R4) Power-on clears all except two lowest set.
// (R5) Software may set/clear flags, never resets.
// (R6) Non power-on resets leave register contents unchanged.
// (R7) Software should clear flags after reading them.
// (R8) Bit 15 set on trap conflict reset.
// (R9) Bit 14 set on bad opcode/working register.
// (R10) Bit 13 enables brown-out detector.
// (R11) Bit 12 selects retention regulator in sleep.
// (R12) Bits 11:10 ignore writes, read zero.
// (R13) Bit 9 flags configuration word mismatch reset.
// (R14) Bit 8 keeps program memory bias in sleep.
// (R15) Bit 7 set on master-clear pin reset.
// (R16) Bit 6 set on reset instruction.
// (R17) Bit 5 enables watchdog; fuse 11 forces on.
// (R18) Bit 4 set on timeout, power-save clears.
// (R19) Bits 3/2 set entering sleep/idle.
// (R20) Bit 1 on brown-out or power-on; 0 power-on.
// (R21) Hardware set wins over software clear.
package reset_combiner_pkg;
	// Byte address of the only register on the bus.
	localparam logic [31:0] CAUSE_REG_ADDR    = 32'h0000_0000;
	// Field positions inside the cause and control register.
	localparam int          TRAP_BIT          = 15;
	localparam int          BAD_OP_BIT        = 14;
	localparam int          BROWNOUT_EN_BIT   = 13;
	localparam int          RETENTION_BIT     = 12;
	localparam int          MISMATCH_BIT      = 9;
	localparam int          PM_BIAS_BIT       = 8;
	localparam int          PIN_RESET_BIT     = 7;
	localparam int          INSTR_RESET_BIT   = 6;
	localparam int          WATCHDOG_EN_BIT   = 5;
	localparam int          TIMEOUT_BIT       = 4;
	localparam int          SLEEP_BIT         = 3;
	localparam int          IDLE_BIT          = 2;
	localparam int          BROWNOUT_BIT      = 1;
	localparam int          POWER_ON_BIT      = 0;
	// Value after power-on, and the bits that software can write.
	localparam logic [15:0] CAUSE_POR_VALUE   = 16'h0003;
	localparam logic [15:0] CAUSE_WRITE_MASK  = 16'hf3ff;
	// Fuse code that keeps the watchdog on regardless of software.
	localparam logic [1:0]  FUSE_WDOG_ALWAYS  = 2'h3;
	// Transfer code of an AHB-Lite address phase that is taken.
	localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
	// Number of asynchronous inputs that pass the synchroniser.
	localparam int          ASYNC_INPUTS      = 4;
endpackage : reset_combiner_pkg

// File: verilog/reset_source_combiner_and_flags.sv
`timescale 1ns/1ns
module reset_source_combiner_and_flags (
	// Clock and asynchronous reset of the bus domain.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave port.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Analog detectors and the pin, all outside the clock domain.
	input  wire logic        power_on_detect,
	input  wire logic        brownout_detect,
	input  wire logic        low_power_brownout,
	input  wire logic        master_clear_pin_n,
	// Reset requests and events from core logic on this clock.
	input  wire logic        reset_instruction,
	input  wire logic        watchdog_reset,
	input  wire logic        trap_conflict,
	input  wire logic        illegal_opcode,
	input  wire logic        uninit_wreg_reset,
	input  wire logic        config_mismatch,
	input  wire logic        sleep_entry,
	input  wire logic        idle_entry,
	// Static configuration fuse of the watchdog.
	input  wire logic [1:0]  fuse_watchdog_mode,
	// Combined reset and control outputs.
	output logic             system_reset_out,
	output logic             brownout_detector_enable,
	output logic             retention_regulator_select,
	output logic             progmem_bias_keep,
	output logic             watchdog_enable
);
	import reset_combiner_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Input synchronisers.
	////////////////////////////////////////////////////////////////////

	// First and second stage of each asynchronous input.
	logic [ASYNC_INPUTS-1:0] sync1_reg;
	logic [ASYNC_INPUTS-1:0] sync2_reg;
	// Raw asynchronous inputs gathered; the pin is turned active high.
	wire  [ASYNC_INPUTS-1:0] async_in;

	assign async_in = {~master_clear_pin_n, low_power_brownout,
		brownout_detect, power_on_detect};

	// Two flip-flops per input; only the second stage feeds any logic.
	generate
		for (genvar i = 0; i < ASYNC_INPUTS; i++) begin : g_sync
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					sync1_reg[i] <= 1'b0;
					sync2_reg[i] <= 1'b0;
				end else begin
					sync1_reg[i] <= async_in[i];
					sync2_reg[i] <= sync1_reg[i];
				end
			end
		end
	endgenerate

	// Synchronised detector and pin levels.
	wire por_s;
	wire bor_s;
	wire low_power_brownout_s;
	wire pin_s;

	assign por_s   = sync2_reg[0];
	assign bor_s   = sync2_reg[1];
	assign low_power_brownout_s = sync2_reg[2];
	assign pin_s   = sync2_reg[3];

	////////////////////////////////////////////////////////////////////
	// Reset combining.
	////////////////////////////////////////////////////////////////////

	// True while any single source requests a reset.
	wire any_source;

	assign any_source = por_s | bor_s | low_power_brownout_s | pin_s // [R1]
		| reset_instruction | watchdog_reset | trap_conflict
		| illegal_opcode | uninit_wreg_reset | config_mismatch;

	// System reset follows the merged request one cycle later.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			system_reset_out <= 1'b1;
		end else begin
			system_reset_out <= any_source; // [R2]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus slave.
	////////////////////////////////////////////////////////////////////

	// Address-phase decode: a taken transfer that hits the register.
	wire take_phase;
	wire hit_reg;

	assign take_phase = hsel & hready & htrans[1];
	assign hit_reg    = (haddr == CAUSE_REG_ADDR);

	// Write pending in the data phase of the register.
	logic wr_pend_reg;

	// Latch the write intent; hsize is ignored as only words are used.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
		end else if (hready) begin
			wr_pend_reg <= take_phase & hwrite & hit_reg;
		end
	end

	// The slave never waits and never reports an error.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Cause and control register.
	////////////////////////////////////////////////////////////////////

	// The register itself and its next value.
	logic [15:0] cause_reg;
	logic [15:0] cause_next;
	// Value after a software write, and the hardware set vector.
	wire  [15:0] sw_value;
	wire  [15:0] hw_set;
	// Software data phase write of the register.
	wire         sw_write;
	// Power-save entry clears the timeout flag.
	wire         pwrsav;

	assign sw_write = wr_pend_reg;
	// Writes may set or clear flags; no reset results from them.
	assign sw_value = sw_write ? (hwdata[15:0] & CAUSE_WRITE_MASK) // [R5]
		: cause_reg;
	assign pwrsav   = sleep_entry | idle_entry;

	// Hardware events set their own flags.
	assign hw_set[TRAP_BIT]        = trap_conflict; // [R8]
	assign hw_set[BAD_OP_BIT]      = illegal_opcode | uninit_wreg_reset; // [R9]
	assign hw_set[BROWNOUT_EN_BIT] = 1'b0;
	assign hw_set[RETENTION_BIT]   = 1'b0;
	assign hw_set[11:10]           = 2'h0; // [R12]
	assign hw_set[MISMATCH_BIT]    = config_mismatch; // [R13]
	assign hw_set[PM_BIAS_BIT]     = 1'b0;
	assign hw_set[PIN_RESET_BIT]   = pin_s; // [R15]
	assign hw_set[INSTR_RESET_BIT] = reset_instruction; // [R16]
	assign hw_set[WATCHDOG_EN_BIT] = 1'b0;
	assign hw_set[TIMEOUT_BIT]     = watchdog_reset; // [R18]
	assign hw_set[SLEEP_BIT]       = sleep_entry; // [R19]
	assign hw_set[IDLE_BIT]        = idle_entry; // [R19]
	assign hw_set[BROWNOUT_BIT]    = bor_s | low_power_brownout_s | por_s; // [R20]
	assign hw_set[POWER_ON_BIT]    = por_s; // [R20]

	// Merge: power-on dominates, then sets, then power-save clear, then write.
	always_comb begin
		cause_next = sw_value;
		if (pwrsav) begin
			cause_next[TIMEOUT_BIT] = 1'b0; // [R18]
		end
		// Sets are applied after both clears so they beat any clear; only power-on comes later.
		cause_next = cause_next | hw_set; // [R3] [R21]
		if (por_s) begin
			cause_next = CAUSE_POR_VALUE; // [R4]
		end
	end

	// Only power-on loads the reset value; other resets keep contents.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_reg <= CAUSE_POR_VALUE; // [R4] [R6]
		end else begin
			cause_reg <= cause_next;
		end
	end

	// Read data registered at the end of the address phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take_phase & ~hwrite & hit_reg) begin
			hrdata <= {16'h0000, cause_reg};
		end else if (hready) begin
			hrdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control outputs.
	////////////////////////////////////////////////////////////////////

	// Fuse code 11 keeps the watchdog on whatever software wants.
	wire wdog_on;

	assign wdog_on = cause_next[WATCHDOG_EN_BIT] // [R17]
		| (fuse_watchdog_mode == FUSE_WDOG_ALWAYS);

	// Outputs track the next register value so they match it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			brownout_detector_enable   <= 1'b0;
			retention_regulator_select <= 1'b0;
			progmem_bias_keep          <= 1'b0;
			watchdog_enable            <= 1'b0;
		end else begin
			brownout_detector_enable   <= cause_next[BROWNOUT_EN_BIT]; // [R10]
			retention_regulator_select <= cause_next[RETENTION_BIT]; // [R11]
			progmem_bias_keep          <= cause_next[PM_BIAS_BIT]; // [R14]
			watchdog_enable            <= wdog_on; // [R17]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions.
	////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Any source raises the reset output on the next edge.
	system_reset_out_any_a : assert property ( // [R2]
		any_source |=> system_reset_out)
		else $error("System reset not raised by an active source.");

	// Without sources the reset output drops on the next edge.
	system_reset_out_idle_a : assert property ( // [R1]
		hresetn && !any_source |=> !system_reset_out)
		else $error("System reset active without any source.");

	// Trap conflict flags bit 15 even against a clearing write.
	trap_flag_a : assert property ( // [R8]
		trap_conflict && !por_s |=> cause_reg[TRAP_BIT])
		else $error("Trap conflict flag not set.");

	// Bad opcode or working register flags bit 14.
	bad_op_flag_a : assert property ( // [R9]
		(illegal_opcode || uninit_wreg_reset) && !por_s
		|=> cause_reg[BAD_OP_BIT])
		else $error("Bad opcode flag not set.");

	// Unimplemented bits never read as one.
	unimpl_zero_a : assert property ( // [R12]
		cause_reg[11:10] == 2'h0)
		else $error("Unimplemented bits are not zero.");

	// Pin reset, seen two edges after the pin, flags bit 7.
	pin_flag_a : assert property ( // [R15]
		pin_s && !por_s |=> cause_reg[PIN_RESET_BIT])
		else $error("Pin reset flag not set.");

	// Reset instruction flags bit 6 and raises system reset.
	instr_flag_a : assert property ( // [R16]
		reset_instruction && !por_s
		|=> cause_reg[INSTR_RESET_BIT] && system_reset_out)
		else $error("Reset instruction flag or reset missing.");

	// Fuse code 11 forces the watchdog on.
	wdog_fuse_a : assert property ( // [R17]
		fuse_watchdog_mode == FUSE_WDOG_ALWAYS |=> watchdog_enable)
		else $error("Watchdog not forced on by fuse.");

	// Power-save without timeout clears the timeout flag.
	timeout_clr_a : assert property ( // [R18]
		pwrsav && !watchdog_reset && !por_s |=> !cause_reg[TIMEOUT_BIT])
		else $error("Timeout flag not cleared by power-save.");

	// Power-on loads exactly the reset value.
	por_value_a : assert property ( // [R4]
		por_s |=> cause_reg == CAUSE_POR_VALUE)
		else $error("Power-on value of register is wrong.");

	// Hardware set beats a clearing software write.
	set_wins_a : assert property ( // [R21]
		sw_write && hwdata[TRAP_BIT] == 1'b0 && trap_conflict && !por_s
		|=> cause_reg[TRAP_BIT])
		else $error("Software clear beat a hardware set.");

	// A software write alone never causes a reset.
	sw_no_reset_a : assert property ( // [R5]
		sw_write && !any_source |=> !system_reset_out)
		else $error("Software write caused a reset.");

endmodule : reset_source_combiner_and_flags
